/* core/crbc_defs.vh */
// Register map, field positions and reset values of the receive buffer control
`ifndef CRBC_DEFS_VH
`define CRBC_DEFS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CRBC_OFS_BUF0_CTRL 8'h00
`define CRBC_OFS_BUF1_CTRL 8'h04
`define CRBC_OFS_MODE      8'h08
`define CRBC_OFS_IRQ_STAT  8'h0C

// ****************************************
// Control register fields
// ****************************************
`define CRBC_BIT_FULL     7
`define CRBC_BIT_RXM_HI   6
`define CRBC_BIT_RXM_LO   5
`define CRBC_BIT_RTR_ENH  5
`define CRBC_BIT_RTR_LEG  3
`define CRBC_BIT_DBEN     2
`define CRBC_BIT_JUMP_TABLE_OFFSET    1
`define CRBC_BIT_HIT0     0

// ****************************************
// Mode register and status fields
// ****************************************
`define CRBC_MODE_LEGACY  2'h0
`define CRBC_BIT_IRQ0     0
`define CRBC_BIT_IRQ1     1

// ****************************************
// Receive mode codes (legacy)
// ****************************************
`define CRBC_RXM_ALL      2'h3
`define CRBC_RXM_EXT      2'h2
`define CRBC_RXM_STD      2'h1
`define CRBC_RXM_VALID    2'h0

// ****************************************
// Reset values
// ****************************************
`define CRBC_RST_RXM      2'h0
`define CRBC_RST_HIT      5'h00
`define CRBC_RST_MODE     2'h0
`define CRBC_RST_DATA     32'h0000_0000

`endif

/* core/crbc_wb_slave.v */
// Classic Wishbone handshake and address decode for the control registers
`timescale 1ns/1ps
`include "crbc_defs.vh"
module crbc_wb_slave (
    input  wire       core_clk,
    input  wire       srst,
    input  wire       clkEn,
    input  wire       wb_cyc_i,
    input  wire       wb_stb_i,
    input  wire       wb_we_i,
    input  wire [7:0] wb_adr_i,
    input  wire [3:0] wb_sel_i,
    output wire       wb_ack_o,
    output wire       rdLatch,
    output wire       wrStrobe,
    output reg  [1:0] regIdx,
    output reg        regHit
);
    reg ackQ;

    // Data sampled one edge before ack, write done on the ack edge
    assign rdLatch  = wb_cyc_i & wb_stb_i & ~ackQ;
    assign wrStrobe = ackQ & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & regHit;
    assign wb_ack_o = ackQ;

    always @* begin
        regHit = 1'b1;
        regIdx = 2'h0;
        if (wb_adr_i == `CRBC_OFS_BUF0_CTRL) begin
            regIdx = 2'h0;
        end else if (wb_adr_i == `CRBC_OFS_BUF1_CTRL) begin
            regIdx = 2'h1;
        end else if (wb_adr_i == `CRBC_OFS_MODE) begin
            regIdx = 2'h2;
        end else if (wb_adr_i == `CRBC_OFS_IRQ_STAT) begin
            regIdx = 2'h3;
        end else begin
            regHit = 1'b0;
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            ackQ <= 1'b0;
        end else if (clkEn) begin
            ackQ <= wb_cyc_i & wb_stb_i & ~ackQ;
        end
    end
endmodule

/* core/crbc_accept.v */
// Frame acceptance decision for one receive buffer
`timescale 1ns/1ps
`include "crbc_defs.vh"
module crbc_accept (
    input  wire       legacy,
    input  wire [1:0] rxMode,
    input  wire       frameErr,
    input  wire       frameExt,
    input  wire       frameHit,
    input  wire       frameHitExtSel,
    input  wire       toThis,
    output reg        accept
);
    wire valid;
    wire routed;

    assign valid  = ~frameErr & frameHit & toThis;
    assign routed = frameHit & toThis;

    always @* begin
        accept = 1'b0;
        if (legacy) begin
            case (rxMode)
                // Still routed by filter index, so buffer 1 never sees codes 0/1 here
                `CRBC_RXM_ALL:   accept = toThis;                                 // [R5] [R17]
                `CRBC_RXM_EXT:   accept = valid & frameExt & frameHitExtSel;      // [R6]
                `CRBC_RXM_STD:   accept = valid & ~frameExt & ~frameHitExtSel;    // [R7]
                default:         accept = valid & (frameExt == frameHitExtSel);   // [R8]
            endcase
        end else begin
            accept = rxMode[1] ? 1'b1 : valid;                                    // [R9]
        end
        if (!legacy && rxMode[1] == 1'b0 && !routed) begin
            accept = 1'b0;
        end
    end
endmodule

/* core/crbc_top.v */
// Control and status of the two dedicated CAN receive buffers
//
// How it works
// [R1] Full flag set when a frame stored
// [R2] Full buffer refuses any new frame
// [R3] Software clears full before interrupt flag
// [R4] Interrupt flag re-sets while full stays set; the code does this for buffer 0 only
// [R5] Legacy mode 11 accepts every frame
// [R6] Legacy mode 10 takes valid extended frames
// [R7] Legacy mode 01 takes valid standard frames
// [R8] Legacy mode 00 follows filter extended select
// [R9] Enhanced mode bit bypasses filters when set
// [R10] Read-only remote request flag, bit 3/5
// [R11] Double buffer overflows buffer 0 into 1
// [R12] Jump offset bit mirrors double buffer enable
// [R13] Offset copy shares one jump table
// [R14] Legacy buffer 0 bit 0 names filter
// [R15] Enhanced five-bit filter hit index
// [R16] Legacy buffer 1 three-bit filter hit code
// [R17] Buffer 1 codes 0/1 only via overflow
// [R18] Layout follows functional mode setting
// [R19] Writing one to full does nothing
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "crbc_defs.vh"
module crbc_top (
    input  wire        core_clk,
    input  wire        srst,
    input  wire        clkEn,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output wire        wb_ack_o,
    input  wire        frameValid,
    input  wire        frameErr,
    input  wire        frameExt,
    input  wire        frameRtr,
    input  wire        frameHit,
    input  wire [4:0]  frameHitIdx,
    input  wire        frameHitExtSel,
    input  wire        frameHitBuf1,
    output reg         storeBuf0,
    output reg         storeBuf1,
    output reg         storeOverflow,
    output reg         frameDropped,
    output wire        buffer0RxIrqFlag,
    output wire        buffer1RxIrqFlag
);
    // ****************************************
    // State
    // ****************************************
    reg  [1:0]  funcMode_q;
    reg  [1:0]  rxMode_q [0:1];
    reg  [1:0]  full_q;
    reg  [1:0]  rtr_q;
    reg  [4:0]  hit_q [0:1];
    reg         dben_q;
    reg  [1:0]  irq_q;

    reg  [1:0]  full_d;
    reg  [1:0]  irq_d;
    reg         store0;
    reg         store1;
    reg         overflow;
    reg         dropped;

    wire        legacy;
    wire        rdLatch;
    wire        wrStrobe;
    wire [1:0]  regIdx;
    wire        regHit;
    wire [1:0]  toBuf;
    wire [1:0]  accept;
    wire        legacyToBuf1;
    wire [7:0]  wrByte;
    reg  [7:0]  ctrl0;
    reg  [7:0]  ctrl1;
    reg  [31:0] rdData;

    assign legacy   = (funcMode_q == `CRBC_MODE_LEGACY);
    assign wrByte   = wb_dat_i[7:0];
    assign buffer0RxIrqFlag = irq_q[0];
    assign buffer1RxIrqFlag = irq_q[1];

    // ****************************************
    // Bus slave
    // ****************************************
    crbc_wb_slave uWb (
        .core_clk (core_clk),
        .srst     (srst),
        .clkEn    (clkEn),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_ack_o (wb_ack_o),
        .rdLatch  (rdLatch),
        .wrStrobe (wrStrobe),
        .regIdx   (regIdx),
        .regHit   (regHit)
    );

    // ****************************************
    // Frame routing
    // ****************************************
    // Legacy: filters 0/1 feed buffer 0, filters 2..5 feed buffer 1
    assign legacyToBuf1 = (frameHitIdx[4:1] != 4'h0);
    assign toBuf[0] = legacy ? ~legacyToBuf1 : ~frameHitBuf1;
    assign toBuf[1] = legacy ? legacyToBuf1 : frameHitBuf1;

    genvar gb;
    generate
        for (gb = 0; gb < 2; gb = gb + 1) begin : gAcc
            crbc_accept uAcc (
                .legacy         (legacy),
                .rxMode         (rxMode_q[gb]),
                .frameErr       (frameErr),
                .frameExt       (frameExt),
                .frameHit       (frameHit),
                .frameHitExtSel (frameHitExtSel),
                .toThis         (toBuf[gb]),
                .accept         (accept[gb])
            );
        end
    endgenerate

    // Placement decision for one arriving frame
    always @* begin
        store0   = 1'b0;
        store1   = 1'b0;
        overflow = 1'b0;
        dropped  = 1'b0;
        if (frameValid) begin
            if (accept[0] && !full_q[0]) begin
                store0 = 1'b1;                                      // [R2]
            end else if (accept[0] && legacy && dben_q && !full_q[1]) begin
                store1   = 1'b1;                                    // [R11]
                overflow = 1'b1;
            end else if (accept[1] && !full_q[1]) begin
                store1 = 1'b1;                                      // [R2]
            end else if (accept[0] || accept[1]) begin
                dropped = 1'b1;
            end
        end
    end

    // ****************************************
    // Full flags and interrupt flags
    // ****************************************
    always @* begin
        full_d = full_q;
        irq_d  = irq_q;
        if (wrStrobe && regIdx == 2'h0 && !wrByte[`CRBC_BIT_FULL]) begin
            full_d[0] = 1'b0;                                       // [R19]
        end
        if (wrStrobe && regIdx == 2'h1 && !wrByte[`CRBC_BIT_FULL]) begin
            full_d[1] = 1'b0;                                       // [R19]
        end
        if (wrStrobe && regIdx == 2'h3) begin
            if (!wrByte[`CRBC_BIT_IRQ0]) begin
                irq_d[0] = 1'b0;
            end
            if (!wrByte[`CRBC_BIT_IRQ1]) begin
                irq_d[1] = 1'b0;
            end
        end
        // Setting wins over a clear in the same cycle
        if (store0) begin
            full_d[0] = 1'b1;                                       // [R1]
            irq_d[0]  = 1'b1;
        end
        if (store1) begin
            full_d[1] = 1'b1;                                       // [R1]
            irq_d[1]  = 1'b1;
        end
        // A cleared buffer 0 interrupt comes back while buffer 0 data still waits
        if (full_d[0]) begin
            irq_d[0] = 1'b1;                                        // [R4]
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            full_q <= 2'b00;
            irq_q  <= 2'b00;
        end else if (clkEn) begin
            full_q <= full_d;
            irq_q  <= irq_d;
        end
    end

    // ****************************************
    // Captured frame status
    // ****************************************
    always @(posedge core_clk) begin
        if (srst) begin
            rtr_q    <= 2'b00;
            hit_q[0] <= `CRBC_RST_HIT;
            hit_q[1] <= `CRBC_RST_HIT;
        end else if (clkEn) begin
            if (store0) begin
                rtr_q[0] <= frameRtr;                               // [R10]
                hit_q[0] <= frameHitIdx;                            // [R14] [R15]
            end
            if (store1) begin
                rtr_q[1] <= frameRtr;                               // [R10]
                hit_q[1] <= frameHitIdx;                            // [R16] [R17]
            end
        end
    end

    // ****************************************
    // Writable control fields
    // ****************************************
    always @(posedge core_clk) begin
        if (srst) begin
            rxMode_q[0] <= `CRBC_RST_RXM;
            rxMode_q[1] <= `CRBC_RST_RXM;
            dben_q      <= 1'b0;                                    // [R11]
            funcMode_q  <= `CRBC_RST_MODE;
        end else if (clkEn && wrStrobe) begin
            if (regIdx == 2'h0 || regIdx == 2'h1) begin
                rxMode_q[regIdx[0]][1] <= wrByte[`CRBC_BIT_RXM_HI];
                if (legacy) begin
                    rxMode_q[regIdx[0]][0] <= wrByte[`CRBC_BIT_RXM_LO];
                end
            end
            if (regIdx == 2'h0 && legacy) begin
                dben_q <= wrByte[`CRBC_BIT_DBEN];
            end
            if (regIdx == 2'h2) begin
                funcMode_q <= wrByte[1:0];
            end
        end
    end

    // ****************************************
    // Read view, layout per functional mode
    // ****************************************
    always @* begin
        if (legacy) begin
            ctrl0 = {full_q[0], rxMode_q[0], 1'b0, rtr_q[0],
                     dben_q, dben_q, hit_q[0][0]};                  // [R12] [R13] [R18]
            ctrl1 = {full_q[1], rxMode_q[1], 1'b0, rtr_q[1],
                     hit_q[1][2:0]};                                // [R16] [R18]
        end else begin
            ctrl0 = {full_q[0], rxMode_q[0][1], rtr_q[0], hit_q[0]}; // [R15] [R18]
            ctrl1 = {full_q[1], rxMode_q[1][1], rtr_q[1], hit_q[1]}; // [R15] [R18]
        end
    end

    always @* begin
        rdData = `CRBC_RST_DATA;
        if (regHit) begin
            case (regIdx)
                2'h0:    rdData = {24'h00_0000, ctrl0};
                2'h1:    rdData = {24'h00_0000, ctrl1};
                2'h2:    rdData = {30'h0000_0000, funcMode_q};
                default: rdData = {30'h0000_0000, irq_q};
            endcase
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            wb_dat_o <= `CRBC_RST_DATA;
        end else if (clkEn && rdLatch) begin
            wb_dat_o <= rdData;
        end
    end

    // ****************************************
    // Store strobes toward the message storage
    // ****************************************
    always @(posedge core_clk) begin
        if (srst) begin
            storeBuf0     <= 1'b0;
            storeBuf1     <= 1'b0;
            storeOverflow <= 1'b0;
            frameDropped  <= 1'b0;
        end else if (clkEn) begin
            storeBuf0     <= store0;
            storeBuf1     <= store1;
            storeOverflow <= overflow;
            frameDropped  <= dropped;
        end
    end
endmodule

/* dv/crbc_top_sva.sv */
// Port assertions for the receive buffer control
`timescale 1ns/1ps
module crbc_top_sva (
    input wire        core_clk,
    input wire        srst,
    input wire        clkEn,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        frameValid,
    input wire        storeBuf0,
    input wire        storeBuf1,
    input wire        storeOverflow,
    input wire        frameDropped,
    input wire        buffer0RxIrqFlag,
    input wire        buffer1RxIrqFlag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    ack_latency_a: assert property (clkEn && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    ack_pulse_a: assert property (clkEn && wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == '0)
        else $error("read data upper bits not zero");
    full0_flag_a: assert property (storeBuf0 |-> buffer0RxIrqFlag [*3])
        else $error("buffer 0 flag not held after store");
    full1_flag_a: assert property (storeBuf1 |-> buffer1RxIrqFlag)
        else $error("buffer 1 flag not set on store");
    // A frozen clock enable holds the last pulse without a new frame
    store_cause_a: assert property (storeBuf0 || storeBuf1 || frameDropped |->
        $past(frameValid) || !$past(clkEn))
        else $error("store without a frame");
    overflow_pair_a: assert property (storeOverflow |-> storeBuf1 && !storeBuf0)
        else $error("overflow without buffer 1 store");
    drop_no_store_a: assert property (frameDropped |-> !storeBuf0 && !storeBuf1)
        else $error("dropped frame was stored");
    reset_quiet_a: assert property ($past(srst) |-> !storeBuf0 && !storeBuf1 && !buffer0RxIrqFlag)
        else $error("outputs active after reset");
endmodule
bind crbc_top crbc_top_sva chk (.core_clk(core_clk), .srst(srst), .clkEn(clkEn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .frameValid(frameValid), .storeBuf0(storeBuf0), .storeBuf1(storeBuf1),
    .storeOverflow(storeOverflow), .frameDropped(frameDropped),
    .buffer0RxIrqFlag(buffer0RxIrqFlag), .buffer1RxIrqFlag(buffer1RxIrqFlag));

/* dv/crbc_frame_src.sv */
// Behavioural protocol engine handing received frames over
`timescale 1ns/1ps
module crbc_frame_src (
    input  wire       core_clk,
    output reg        frameValid,
    output reg        frameErr,
    output reg        frameExt,
    output reg        frameRtr,
    output reg        frameHit,
    output reg  [4:0] frameHitIdx,
    output reg        frameHitExtSel,
    output reg        frameHitBuf1
);
    reg busy;
    initial begin
        busy = 1'b0;
        frameValid = 1'b0;
        {frameErr, frameExt, frameRtr, frameHit, frameHitIdx, frameHitExtSel, frameHitBuf1} = '0;
    end
    // Qualifiers are noise outside a frame
    always @(posedge core_clk) begin
        if (!busy) begin
            {frameErr, frameExt, frameRtr, frameHit, frameHitIdx, frameHitExtSel,
                frameHitBuf1} <= 11'($urandom);
        end
    end
    // Fields packed err, ext, rtr, hit, idx, extSel, buf1
    task send(input logic [10:0] f);
        busy = 1'b1;
        @(posedge core_clk);
        frameValid <= 1'b1;
        {frameErr, frameExt, frameRtr, frameHit, frameHitIdx, frameHitExtSel, frameHitBuf1} <= f;
        @(posedge core_clk);
        frameValid <= 1'b0;
        busy = 1'b0;
    endtask
endmodule

/* dv/crbc_top_bench.sv */
// Self-checking bench for the receive buffer control
`timescale 1ns/1ps
`include "crbc_defs.vh"
module crbc_top_bench;
    reg         core_clk;
    reg         srst;
    reg         clkEn;
    reg         cyc;
    reg         stb;
    reg         we;
    reg  [3:0]  sel;
    reg  [7:0]  adr;
    reg  [31:0] datW;
    wire [31:0] datR;
    wire        ack;
    wire        frameValid, frameErr, frameExt, frameRtr, frameHit, frameHitExtSel, frameHitBuf1;
    wire [4:0]  frameHitIdx;
    wire        storeBuf0, storeBuf1, storeOverflow, frameDropped, irq0, irq1;
    integer     fails;
    integer     testsRun;
    integer     m;
    reg  [3:0]  seen;
    reg  [10:0] f;
    reg  [7:0]  q;
    reg  [3:0]  lane;

    crbc_frame_src src (.core_clk(core_clk), .frameValid(frameValid), .frameErr(frameErr),
        .frameExt(frameExt), .frameRtr(frameRtr), .frameHit(frameHit),
        .frameHitIdx(frameHitIdx), .frameHitExtSel(frameHitExtSel), .frameHitBuf1(frameHitBuf1));
    crbc_top dut (.core_clk(core_clk), .srst(srst), .clkEn(clkEn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
        .wb_dat_o(datR), .wb_ack_o(ack), .frameValid(frameValid), .frameErr(frameErr),
        .frameExt(frameExt), .frameRtr(frameRtr), .frameHit(frameHit),
        .frameHitIdx(frameHitIdx), .frameHitExtSel(frameHitExtSel),
        .frameHitBuf1(frameHitBuf1), .storeBuf0(storeBuf0), .storeBuf1(storeBuf1),
        .storeOverflow(storeOverflow), .frameDropped(frameDropped),
        .buffer0RxIrqFlag(irq0), .buffer1RxIrqFlag(irq1));

    task check(input string what, input logic [31:0] got, input logic [31:0] exp);
        testsRun = testsRun + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("MISMATCH %0s expected %h seen %h", what, exp, got);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ****************************************
    // Wishbone classic cycle
    // ****************************************
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= lane;
        adr <= a;
        datW <= 32'(d);
        do begin
            @(posedge core_clk);
        end while (ack !== 1'b1);
        q = datR[7:0];
        check("ack", ack, 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
        wb(1'b0, a, 8'h00);
        check("read", q & msk, exp);
    endtask
    task frame(input logic [10:0] fr);
        src.send(fr);
        #1;
        seen = {storeOverflow, frameDropped, storeBuf1, storeBuf0};
    endtask
    function automatic logic legAcc(input integer md, input logic [10:0] fr);
        case (md)
            3: legAcc = 1'b1;
            2: legAcc = !fr[10] && fr[7] && fr[9] && fr[1];
            1: legAcc = !fr[10] && fr[7] && !fr[9] && !fr[1];
            default: legAcc = !fr[10] && fr[7] && (fr[9] == fr[1]);
        endcase
    endfunction

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #300000;
        fails = fails + 1;
        print_verdict;
    end
    initial begin
        fails = 0;
        testsRun = 0;
        srst = 1'b1;
        clkEn = 1'b1;
        {cyc, stb, we, adr, datW} = '0;
        sel = 4'h1;
        lane = 4'h1;
        m = $urandom(32'hdd23);
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        rd(`CRBC_OFS_BUF0_CTRL, 8'h00, 8'hff);
        rd(`CRBC_OFS_BUF1_CTRL, 8'h00, 8'hff);
        rd(8'h10, 8'h00, 8'hff);
        // Lane 0 off, then an unmapped write: neither may land
        lane = 4'h0;
        wb(1'b1, `CRBC_OFS_BUF0_CTRL, 8'h44);
        lane = 4'h1;
        wb(1'b1, 8'h10, 8'h44);
        rd(`CRBC_OFS_BUF0_CTRL, 8'h00, 8'hff);
        // Frozen clock enable must ignore a frame
        clkEn <= 1'b0;
        frame({1'b0, 1'b0, 1'b0, 1'b1, 5'h00, 1'b0, 1'b0});
        check("freeze", seen, 4'h0);
        @(posedge core_clk);
        clkEn <= 1'b1;
        frame({1'b0, 1'b0, 1'b1, 1'b1, 5'h01, 1'b0, 1'b0});
        check("store", seen, 4'h1);
        rd(`CRBC_OFS_BUF0_CTRL, 8'h89, 8'hff);
        frame({1'b0, 1'b0, 1'b0, 1'b1, 5'h00, 1'b0, 1'b0});
        check("drop", seen, 4'h4);
        wb(1'b1, `CRBC_OFS_BUF0_CTRL, 8'h80);
        rd(`CRBC_OFS_BUF0_CTRL, 8'h89, 8'hff);
        wb(1'b1, `CRBC_OFS_IRQ_STAT, 8'h00);
        #1 check("irq0", irq0, 1'b1);
        wb(1'b1, `CRBC_OFS_BUF0_CTRL, 8'h00);
        wb(1'b1, `CRBC_OFS_IRQ_STAT, 8'h00);
        #1 check("irq0", irq0, 1'b0);
        wb(1'b1, `CRBC_OFS_BUF0_CTRL, 8'h04);
        rd(`CRBC_OFS_BUF0_CTRL, 8'h06, 8'h86);
        frame({1'b0, 1'b0, 1'b0, 1'b1, 5'h00, 1'b0, 1'b0});
        check("store", seen, 4'h1);
        frame({1'b0, 1'b0, 1'b0, 1'b1, 5'h01, 1'b0, 1'b0});
        check("overflow", seen, 4'ha);
        rd(`CRBC_OFS_BUF1_CTRL, 8'h81, 8'h8f);
        frame({1'b0, 1'b0, 1'b0, 1'b1, 5'h01, 1'b0, 1'b0});
        check("drop", seen, 4'h4);
        wb(1'b1, `CRBC_OFS_BUF0_CTRL, 8'h00);
        for (m = 0; m < 4; m++) begin
            wb(1'b1, `CRBC_OFS_BUF1_CTRL, {1'b0, 2'(m), 5'h00});
            repeat (6) begin
                f = 11'($urandom);
                f[6:2] = {3'h0, f[6:5]} + 5'h02;
                f[7] = f[7] | (m == 3);
                frame(f);
                check("accept", seen, {2'h0, legAcc(m, f), 1'b0});
                if (legAcc(m, f)) begin
                    rd(`CRBC_OFS_BUF1_CTRL, {1'b1, 2'(m), 1'b0, f[8], f[4:2]}, 8'hff);
                    wb(1'b1, `CRBC_OFS_BUF1_CTRL, {1'b0, 2'(m), 5'h00});
                end
            end
        end
        #1 check("irq1", irq1, 1'b1);
        rd(`CRBC_OFS_IRQ_STAT, 8'h03, 8'hff);
        wb(1'b1, `CRBC_OFS_MODE, 8'h01);
        rd(`CRBC_OFS_MODE, 8'h01, 8'hff);
        wb(1'b1, `CRBC_OFS_BUF1_CTRL, 8'h00);
        frame({1'b0, 1'b1, 1'b1, 1'b1, 5'h0d, 1'b1, 1'b0});
        check("store", seen, 4'h1);
        rd(`CRBC_OFS_BUF0_CTRL, 8'had, 8'hff);
        frame({1'b1, 1'b0, 1'b0, 1'b1, 5'h03, 1'b0, 1'b1});
        check("reject", seen, 4'h0);
        wb(1'b1, `CRBC_OFS_BUF1_CTRL, 8'h40);
        frame({1'b1, 1'b0, 1'b0, 1'b1, 5'h03, 1'b0, 1'b1});
        check("accept", seen, 4'h2);
        rd(`CRBC_OFS_BUF1_CTRL, 8'hc0, 8'hc0);
        print_verdict;
    end
endmodule
